// ### aux_area_pkg.sv
// constants, field positions and carrier types of the auxiliary area bank
package aux_area_pkg;

	// word indices; the byte address on the bus is four times the index
	localparam logic [4:0] W_UNIT_ERR = 5'h00;
	localparam logic [4:0] W_RESTART = 5'h01;
	localparam logic [4:0] W_SLAVE_DENSE = 5'h02;
	localparam logic [4:0] W_OPTICAL0 = 5'h03;
	localparam logic [4:0] W_LINK_HIST = 5'h07;
	localparam logic [4:0] W_NODES_L0 = 5'h08;
	localparam logic [4:0] W_NODES_L1 = 5'h0c;
	localparam logic [4:0] W_SVC_L0 = 5'h10;
	localparam logic [4:0] W_SVC_L1 = 5'h11;
	localparam logic [4:0] W_CALENDAR = 5'h12;
	localparam logic [4:0] W_CALENDAR_LAST = 5'h15;
	localparam logic [4:0] W_CONSOLE_KEYS = 5'h16;
	localparam logic [4:0] W_POWER_OFF = 5'h17;
	localparam logic [4:0] W_MOUNTED = 5'h18;
	localparam logic [4:0] W_FALS_ADDR = 5'h19;
	localparam logic [4:0] W_MAX_CYCLE = 5'h1a;
	localparam logic [4:0] W_CUR_CYCLE = 5'h1b;
	localparam logic [4:0] W_IRQ_STATUS = 5'h1c;
	localparam logic [4:0] W_IRQ_MASK = 5'h1d;
	localparam int NUM_WORDS = 28;
	localparam int NUM_OPTICAL_WORDS = 4;
	localparam int ADDR_W = 8;

	// writable bits and reset values
	localparam logic [15:0] MASK_RESTART = 16'hcfff;
	localparam logic [15:0] MASK_LINK_HIST = 16'he1ff;
	localparam logic [15:0] AREA_RESET = 16'h0000;

	// fields of the slave / high-density word
	localparam int B_DENSE_LSB = 5;
	localparam int B_DENSE_UNKNOWN = 15;

	// fields of the link and history word
	localparam int B_LINK_L0_LSB = 0;
	localparam int B_LINK_L1_LSB = 4;
	localparam int B_KEY_CANCEL = 8;
	localparam int B_HIST_OVERWRITE = 13;
	localparam int B_HIST_RESET = 14;
	localparam int B_HIST_ENABLE = 15;

	// fields of the mounted and battery word
	localparam int B_LOW_BATT = 4;
	localparam int B_CYCLE_FLAG = 5;
	localparam int B_NETP_L1 = 6;
	localparam int B_NETP_L0 = 7;
	localparam int B_LINK_MNT_L1 = 8;
	localparam int B_LINK_MNT_L0 = 9;
	localparam int B_PCLINK_MNT_L1 = 11;
	localparam int B_PCLINK_MNT_L0 = 12;
	localparam int B_HOST_MNT_L1 = 13;
	localparam int B_HOST_MNT_L0 = 14;
	localparam int B_CPU_DEV_MNT = 15;

	// interrupt status bits
	localparam int IRQ_BITS = 5;
	localparam int ST_UNIT = 0;
	localparam int ST_SLAVE = 1;
	localparam int ST_DENSE = 2;
	localparam int ST_OPTICAL = 3;
	localparam int ST_LOW_BATT = 4;
	localparam logic [IRQ_BITS-1:0] IRQ_RESET = 5'h00;

	// detection events from the unit-side logic
	typedef struct packed {
		logic [15:0] unit_err;
		logic startup;
		logic [4:0] slave_dup;
		logic [4:0] slave_xmit;
		logic [9:0] dense_dup_num;
		logic [9:0] dense_dup_word;
		logic dense_num9_64pt;
		logic [9:0] dense_fuse;
		logic dense_unknown;
		logic [63:0] optical_dup;
		logic err_clear;
	} err_evt_t;

	// system state refreshed each scan
	typedef struct packed {
		logic [63:0] nodes_l0;
		logic [63:0] nodes_l1;
		logic [15:0] svc_l0;
		logic [15:0] svc_l1;
		logic [15:0] power_off;
		logic [15:0] fals_addr;
		logic [15:0] max_cycle;
		logic [15:0] cur_cycle;
		logic low_batt;
		logic cycle_flag;
		logic netp_l1;
		logic netp_l0;
		logic link_mnt_l1;
		logic link_mnt_l0;
		logic pclink_mnt_l1;
		logic pclink_mnt_l0;
		logic host_mnt_l1;
		logic host_mnt_l0;
		logic cpu_dev_mnt;
	} sys_state_t;

	// control bits written by the user program
	typedef struct packed {
		logic [15:0] restart;
		logic [3:0] link_set_l0;
		logic [3:0] link_set_l1;
		logic key_cancel;
		logic hist_overwrite;
		logic hist_reset;
		logic hist_enable;
		logic [15:0] console_keys;
		logic [63:0] calendar;
	} ctrl_out_t;

endpackage

// ### aux_flag_area_bank.sv
// auxiliary flag and control word bank behind an apb slave
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps

module aux_flag_area_bank (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [aux_area_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// unit-side detection and system state
	input wire aux_area_pkg::err_evt_t evt,
	input wire aux_area_pkg::sys_state_t sys,
	// control bits to the controller
	output aux_area_pkg::ctrl_out_t ctrl,
	// interrupt
	output logic irq
);

	logic [15:0] area_reg [0:aux_area_pkg::NUM_WORDS-1];
	logic [15:0] area_next [0:aux_area_pkg::NUM_WORDS-1];
	logic [aux_area_pkg::IRQ_BITS-1:0] status_reg;
	logic [aux_area_pkg::IRQ_BITS-1:0] status_next;
	logic [aux_area_pkg::IRQ_BITS-1:0] mask_reg;
	logic [aux_area_pkg::IRQ_BITS-1:0] mask_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic [4:0] idx;
	logic mapped;
	logic wr_en;
	logic [15:0] wdata;
	logic [15:0] slave_set;
	logic [9:0] dense_set;
	logic [15:0] w24;

	// word index and decode of the bus address
	assign idx = paddr[6:2];
	assign wdata = pwdata[15:0];
	always_comb begin
		mapped = 1'b0;
		if (paddr[7] || (paddr[1:0] != 2'b00)) begin
			mapped = 1'b0;
		end else if (idx < 5'(aux_area_pkg::NUM_WORDS)) begin
			mapped = 1'b1;
		end else if (idx == aux_area_pkg::W_IRQ_STATUS) begin
			mapped = 1'b1;
		end else if (idx == aux_area_pkg::W_IRQ_MASK) begin
			mapped = 1'b1;
		end
	end

	// zero wait state: data is captured in setup, answered in access
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wr_en = psel && penable && pwrite && mapped;
	assign prdata = prdata_reg;

	// set terms of the slave flags, gated by startup, and of the ungated high-density flags
	always_comb begin
		slave_set = 16'h0000;
		if (evt.startup) begin
			slave_set[4:0] = evt.slave_dup | evt.slave_xmit;
		end
		dense_set = evt.dense_dup_num | evt.dense_dup_word | evt.dense_fuse;
		dense_set[9] = dense_set[9] | evt.dense_num9_64pt;
	end

	// mounted and battery word built from the system state
	always_comb begin
		w24 = 16'h0000;
		w24[aux_area_pkg::B_LOW_BATT] = sys.low_batt;
		w24[aux_area_pkg::B_CYCLE_FLAG] = sys.cycle_flag;
		w24[aux_area_pkg::B_NETP_L1] = sys.netp_l1;
		w24[aux_area_pkg::B_NETP_L0] = sys.netp_l0;
		w24[aux_area_pkg::B_LINK_MNT_L1] = sys.link_mnt_l1;
		w24[aux_area_pkg::B_LINK_MNT_L0] = sys.link_mnt_l0;
		w24[aux_area_pkg::B_PCLINK_MNT_L1] = sys.pclink_mnt_l1;
		w24[aux_area_pkg::B_PCLINK_MNT_L0] = sys.pclink_mnt_l0;
		w24[aux_area_pkg::B_HOST_MNT_L1] = sys.host_mnt_l1;
		w24[aux_area_pkg::B_HOST_MNT_L0] = sys.host_mnt_l0;
		w24[aux_area_pkg::B_CPU_DEV_MNT] = sys.cpu_dev_mnt;
	end

	// next contents of the area: flags, refreshed words, user writes
	always_comb begin
		for (int i = 0; i < aux_area_pkg::NUM_WORDS; i++) begin
			area_next[i] = area_reg[i];
		end
		// a detection clear empties the error flags, but a set wins
		if (evt.err_clear) begin
			area_next[aux_area_pkg::W_UNIT_ERR] = 16'h0000;
			area_next[aux_area_pkg::W_SLAVE_DENSE] = 16'h0000;
			for (int i = 0; i < aux_area_pkg::NUM_OPTICAL_WORDS; i++) begin
				area_next[int'(aux_area_pkg::W_OPTICAL0) + i] = 16'h0000;
			end
		end
		area_next[aux_area_pkg::W_UNIT_ERR] =
			area_next[aux_area_pkg::W_UNIT_ERR] | evt.unit_err;
		area_next[aux_area_pkg::W_SLAVE_DENSE] =
			area_next[aux_area_pkg::W_SLAVE_DENSE] | slave_set;
		area_next[aux_area_pkg::W_SLAVE_DENSE][aux_area_pkg::B_DENSE_LSB +: 10] =
			area_next[aux_area_pkg::W_SLAVE_DENSE][aux_area_pkg::B_DENSE_LSB +: 10]
			| dense_set;
		area_next[aux_area_pkg::W_SLAVE_DENSE][aux_area_pkg::B_DENSE_UNKNOWN] =
			area_next[aux_area_pkg::W_SLAVE_DENSE][aux_area_pkg::B_DENSE_UNKNOWN]
			| evt.dense_unknown;
		// optical unit n half h is flat bit 2n+h, 16 bits per word
		for (int i = 0; i < aux_area_pkg::NUM_OPTICAL_WORDS; i++) begin
			area_next[int'(aux_area_pkg::W_OPTICAL0) + i] =
				area_next[int'(aux_area_pkg::W_OPTICAL0) + i]
				| evt.optical_dup[16*i +: 16];
		end
		// words refreshed every scan from the system state
		for (int i = 0; i < 4; i++) begin
			area_next[int'(aux_area_pkg::W_NODES_L0) + i] =
				sys.nodes_l0[16*i +: 16];
			area_next[int'(aux_area_pkg::W_NODES_L1) + i] =
				sys.nodes_l1[16*i +: 16];
		end
		area_next[aux_area_pkg::W_SVC_L0] = sys.svc_l0;
		area_next[aux_area_pkg::W_SVC_L1] = sys.svc_l1;
		area_next[aux_area_pkg::W_POWER_OFF] = sys.power_off;
		area_next[aux_area_pkg::W_MOUNTED] = w24;
		area_next[aux_area_pkg::W_FALS_ADDR] = sys.fals_addr;
		area_next[aux_area_pkg::W_MAX_CYCLE] = sys.max_cycle;
		area_next[aux_area_pkg::W_CUR_CYCLE] = sys.cur_cycle;
		// only control words take user writes; flag words ignore them
		if (wr_en) begin
			if (idx == aux_area_pkg::W_RESTART) begin
				area_next[idx] = wdata & aux_area_pkg::MASK_RESTART;
			end else if (idx == aux_area_pkg::W_LINK_HIST) begin
				area_next[idx] = wdata & aux_area_pkg::MASK_LINK_HIST;
			end else if (idx >= aux_area_pkg::W_CALENDAR
				&& idx <= aux_area_pkg::W_CALENDAR_LAST) begin
				area_next[idx] = wdata;
			end else if (idx == aux_area_pkg::W_CONSOLE_KEYS) begin
				area_next[idx] = wdata;
			end
		end
	end

	// area storage: the power-on reset clears all of it, a detection clear only the error words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < aux_area_pkg::NUM_WORDS; i++) begin
				area_reg[i] <= aux_area_pkg::AREA_RESET;
			end
		end else begin
			for (int i = 0; i < aux_area_pkg::NUM_WORDS; i++) begin
				area_reg[i] <= area_next[i];
			end
		end
	end

	// sticky interrupt status, write one to clear, set wins
	always_comb begin
		logic [aux_area_pkg::IRQ_BITS-1:0] evt_vec;
		evt_vec = '0;
		evt_vec[aux_area_pkg::ST_UNIT] = |evt.unit_err;
		evt_vec[aux_area_pkg::ST_SLAVE] = |slave_set;
		evt_vec[aux_area_pkg::ST_DENSE] = (|dense_set) | evt.dense_unknown;
		evt_vec[aux_area_pkg::ST_OPTICAL] = |evt.optical_dup;
		evt_vec[aux_area_pkg::ST_LOW_BATT] = sys.low_batt
			&& !area_reg[aux_area_pkg::W_MOUNTED][aux_area_pkg::B_LOW_BATT];
		status_next = status_reg;
		mask_next = mask_reg;
		if (wr_en && idx == aux_area_pkg::W_IRQ_STATUS) begin
			status_next = status_reg & ~pwdata[aux_area_pkg::IRQ_BITS-1:0];
		end else if (wr_en && idx == aux_area_pkg::W_IRQ_MASK) begin
			mask_next = pwdata[aux_area_pkg::IRQ_BITS-1:0];
		end
		status_next = status_next | evt_vec;
	end

	// interrupt registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= aux_area_pkg::IRQ_RESET;
			mask_reg <= aux_area_pkg::IRQ_RESET;
		end else begin
			status_reg <= status_next;
			mask_reg <= mask_next;
		end
	end

	assign irq = |(status_reg & mask_reg);

	// read data picked in the setup cycle
	always_comb begin
		prdata_next = prdata_reg;
		if (psel && !penable && !pwrite) begin
			prdata_next = 32'h0000_0000;
			if (!mapped) begin
				prdata_next = 32'h0000_0000;
			end else if (idx < 5'(aux_area_pkg::NUM_WORDS)) begin
				prdata_next = {16'h0000, area_reg[idx]};
			end else if (idx == aux_area_pkg::W_IRQ_STATUS) begin
				prdata_next = {27'h0, status_reg};
			end else if (idx == aux_area_pkg::W_IRQ_MASK) begin
				prdata_next = {27'h0, mask_reg};
			end
		end
	end

	// read data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else begin
			prdata_reg <= prdata_next;
		end
	end

	// control outputs straight from the stored words
	assign ctrl.restart = area_reg[aux_area_pkg::W_RESTART];
	assign ctrl.link_set_l0 = area_reg[aux_area_pkg::W_LINK_HIST]
		[aux_area_pkg::B_LINK_L0_LSB +: 4];
	assign ctrl.link_set_l1 = area_reg[aux_area_pkg::W_LINK_HIST]
		[aux_area_pkg::B_LINK_L1_LSB +: 4];
	assign ctrl.key_cancel = area_reg[aux_area_pkg::W_LINK_HIST]
		[aux_area_pkg::B_KEY_CANCEL];
	assign ctrl.hist_overwrite = area_reg[aux_area_pkg::W_LINK_HIST]
		[aux_area_pkg::B_HIST_OVERWRITE];
	assign ctrl.hist_reset = area_reg[aux_area_pkg::W_LINK_HIST]
		[aux_area_pkg::B_HIST_RESET];
	assign ctrl.hist_enable = area_reg[aux_area_pkg::W_LINK_HIST]
		[aux_area_pkg::B_HIST_ENABLE];
	assign ctrl.console_keys = area_reg[aux_area_pkg::W_CONSOLE_KEYS];
	assign ctrl.calendar = {area_reg[21], area_reg[20], area_reg[19],
		area_reg[18]};

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_wr_restart;
		psel && penable && pwrite && idx == aux_area_pkg::W_RESTART
			&& mapped;
	endsequence

	sequence s_wr_link;
		psel && penable && pwrite && idx == aux_area_pkg::W_LINK_HIST
			&& mapped;
	endsequence

	sequence s_wr_flags;
		psel && penable && pwrite && idx == aux_area_pkg::W_UNIT_ERR
			&& evt.unit_err == 16'h0000 && !evt.err_clear;
	endsequence

	a_unit_flag_set: assert property (
		evt.unit_err[9] |=> area_reg[0][9] ##1 (area_reg[0][9] || $past(evt.err_clear)))
		else $error("special unit flag not set");
	a_master_flag_set: assert property (
		evt.unit_err[15] && !evt.err_clear |=> area_reg[0][15] [*2] or (##1 $past(evt.err_clear)))
		else $error("remote master flag not set");
	a_restart_write: assert property (
		s_wr_restart |=> area_reg[1] == ($past(pwdata[15:0]) & 16'hcfff))
		else $error("restart word write wrong");
	a_slave_set: assert property (
		evt.startup && evt.slave_xmit[2] |=> area_reg[2][2])
		else $error("slave flag not set");
	a_slave_gated: assert property (
		!evt.startup && !area_reg[2][0] |=> !area_reg[2][0])
		else $error("slave flag set outside startup");
	a_dense_map: assert property (
		evt.dense_fuse[3] |=> area_reg[2][8])
		else $error("high density flag in wrong bit");
	a_dense_num9: assert property (
		evt.dense_num9_64pt |=> area_reg[2][14])
		else $error("number nine fault not flagged");
	a_dense_unknown: assert property (
		evt.dense_unknown |=> area_reg[2][15])
		else $error("unknown unit not flagged");
	a_optical_map: assert property (
		evt.optical_dup[27] |=> area_reg[4][11])
		else $error("optical flag in wrong bit");
	a_link_setting: assert property (
		s_wr_link |=> ctrl.link_set_l1 == $past(pwdata[7:4])
			&& ctrl.link_set_l0 == $past(pwdata[3:0]))
		else $error("link setting not stored");
	a_battery_bit: assert property (
		##1 area_reg[24][4] == $past(sys.low_batt)
			&& area_reg[24][3:0] == 4'h0)
		else $error("battery bit wrong");
	a_flags_ro: assert property (
		s_wr_flags |=> area_reg[0] == $past(area_reg[0]))
		else $error("user write changed error flags");
	a_irq_raise: assert property (
		evt.unit_err != 16'h0000 && mask_reg[0]
			&& !(wr_en && idx == aux_area_pkg::W_IRQ_MASK) |=> irq)
		else $error("interrupt not raised");

	sequence s_wr_mounted;
		psel && penable && pwrite && mapped
			&& idx == aux_area_pkg::W_MOUNTED;
	endsequence

	sequence s_wr_keys;
		psel && penable && pwrite && mapped
			&& idx == aux_area_pkg::W_CONSOLE_KEYS;
	endsequence

	a_mounted_ro: assert property (
		s_wr_mounted |=> area_reg[24] == $past(w24))
		else $error("user write changed mounted flags");
	a_keys_write: assert property (
		s_wr_keys |=> ctrl.console_keys == $past(pwdata[15:0]))
		else $error("console key word not stored");
	a_keys_retain: assert property (
		!(wr_en && idx == aux_area_pkg::W_CONSOLE_KEYS)
			|=> area_reg[22] == $past(area_reg[22]))
		else $error("console key word lost its value");
	a_unit_clear: assert property (
		evt.err_clear && evt.unit_err == 16'h0000
			|=> area_reg[0] == 16'h0000)
		else $error("error flags not cleared");
	a_slave_dup: assert property (
		evt.startup && evt.slave_dup[4] |=> area_reg[2][4])
		else $error("slave duplicate not flagged");
	a_dense_word: assert property (
		evt.dense_dup_word[0] |=> area_reg[2][5])
		else $error("shared word fault not flagged");
	a_dense_number: assert property (
		evt.dense_dup_num[9] |=> area_reg[2][14])
		else $error("duplicate number not flagged");
	a_optical_low: assert property (
		evt.optical_dup[0] |=> area_reg[3][0])
		else $error("first optical flag in wrong bit");
	a_optical_high: assert property (
		evt.optical_dup[63] |=> area_reg[6][15])
		else $error("last optical flag in wrong bit");
	a_optical_only: assert property (
		evt.optical_dup[15:0] == 16'h0000 && !evt.err_clear
			|=> area_reg[3] == $past(area_reg[3]))
		else $error("optical flag changed without duplicate");
	a_restart_gap: assert property (
		area_reg[1][13:12] == 2'b00)
		else $error("unused restart bits set");
	a_link_gap: assert property (
		area_reg[7][12:9] == 4'h0)
		else $error("unused link word bits set");
	a_hist_bits: assert property (
		s_wr_link |=> ctrl.hist_enable == $past(pwdata[15])
			&& ctrl.key_cancel == $past(pwdata[8]))
		else $error("history or key cancel bit not stored");
	a_nodes_copy: assert property (
		##1 area_reg[8] == $past(sys.nodes_l0[15:0])
			&& area_reg[15] == $past(sys.nodes_l1[63:48]))
		else $error("active node words not refreshed");
	a_mounted_bits: assert property (
		##1 area_reg[24][15] == $past(sys.cpu_dev_mnt)
			&& area_reg[24][10] == 1'b0)
		else $error("mounted flags wrong");

endmodule // aux_flag_area_bank

// ### unit_side_model.sv
// behavioural model of the unit-side detection logic and scan state
`timescale 1ns/1ps
module unit_side_model (
	// clock
	input wire logic pclk,
	// detection events and refreshed system state
	output aux_area_pkg::err_evt_t evt,
	output aux_area_pkg::sys_state_t sys
);
	// idle: no events, nothing mounted
	initial begin
		evt = '0;
		sys = '0;
	end

	// one-cycle detection pulse, launched just after an edge
	task automatic fire(input aux_area_pkg::err_evt_t e);
		@(posedge pclk);
		evt <= e;
		@(posedge pclk);
		evt <= '0;
	endtask

	// new scan state, held until the next refresh
	task automatic refresh(input aux_area_pkg::sys_state_t s);
		@(posedge pclk);
		sys <= s;
	endtask
endmodule // unit_side_model

// ### test_aux_flag_area_bank.sv
// self-checking bench for the auxiliary flag area bank
`timescale 1ns/1ps
module test_aux_flag_area_bank;
	// clock, reset and apb
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	// unit side and controller side
	aux_area_pkg::err_evt_t evt;
	aux_area_pkg::sys_state_t sys;
	aux_area_pkg::ctrl_out_t ctrl;
	int fails = 0;
	int n_tests = 0;

	unit_side_model partner (.pclk(pclk), .evt(evt), .sys(sys));

	aux_flag_area_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .evt(evt), .sys(sys), .ctrl(ctrl), .irq(irq));

	// 40 mhz clock
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer; waits for pready in the access phase
	task automatic apb(input logic wr, input logic [4:0] idx,
		input logic [31:0] d, output logic [31:0] q, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {1'b0, idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	// mapped write, no error expected
	task automatic wr(input logic [4:0] idx, input logic [15:0] d);
		logic [31:0] q;
		logic er;
		apb(1'b1, idx, {16'h0000, d}, q, er);
		check({31'h0, er}, 32'h0);
	endtask

	// mapped read against an expected word
	task automatic rd_chk(input logic [4:0] idx, input logic [15:0] exp);
		logic [31:0] q;
		logic er;
		apb(1'b0, idx, 32'h0, q, er);
		check(q, {16'h0000, exp});
		check({31'h0, er}, 32'h0);
	endtask

	// detection side wipes all error words
	task automatic clr;
		aux_area_pkg::err_evt_t e;
		e = '0;
		e.err_clear = 1'b1;
		partner.fire(e);
	endtask

	task automatic t_reset;
		logic [31:0] q;
		logic er;
		rd_chk(aux_area_pkg::W_UNIT_ERR, 16'h0000);
		rd_chk(aux_area_pkg::W_LINK_HIST, 16'h0000);
		apb(1'b0, 5'h1e, 32'h0, q, er);
		check({q[31:1], er}, 32'h1);
		apb(1'b1, 5'h1f, 32'hffff, q, er);
		check({31'h0, er}, 32'h1);
		$display("test reset done");
	endtask

	task automatic t_unit;
		aux_area_pkg::err_evt_t e;
		e = '0;
		e.unit_err = 16'ha7c3;
		partner.fire(e);
		rd_chk(aux_area_pkg::W_UNIT_ERR, 16'ha7c3);
		rd_chk(aux_area_pkg::W_OPTICAL0, 16'h0000);
		wr(aux_area_pkg::W_UNIT_ERR, 16'h0000);
		rd_chk(aux_area_pkg::W_UNIT_ERR, 16'ha7c3);
		clr;
		rd_chk(aux_area_pkg::W_UNIT_ERR, 16'h0000);
		$display("test unit flags done");
	endtask

	task automatic t_restart;
		wr(aux_area_pkg::W_RESTART, 16'hffff);
		rd_chk(aux_area_pkg::W_RESTART, 16'hcfff);
		check(ctrl.restart, 16'hcfff);
		wr(aux_area_pkg::W_RESTART, 16'h3000);
		rd_chk(aux_area_pkg::W_RESTART, 16'h0000);
		$display("test restart done");
	endtask

	task automatic t_slave;
		aux_area_pkg::err_evt_t e;
		e = '0;
		e.slave_dup = 5'h1f;
		partner.fire(e);
		rd_chk(aux_area_pkg::W_SLAVE_DENSE, 16'h0000);
		e.startup = 1'b1;
		e.slave_dup = 5'h15;
		partner.fire(e);
		rd_chk(aux_area_pkg::W_SLAVE_DENSE, 16'h0015);
		clr;
		e.slave_dup = 5'h00;
		e.slave_xmit = 5'h16;
		partner.fire(e);
		rd_chk(aux_area_pkg::W_SLAVE_DENSE, 16'h0016);
		clr;
		$display("test slave flags done");
	endtask

	task automatic t_dense;
		aux_area_pkg::err_evt_t e;
		for (int c = 0; c < 3; c++) begin
			for (int k = 0; k < 10; k++) begin
				e = '0;
				case (c)
					0: e.dense_dup_num[k] = 1'b1;
					1: e.dense_dup_word[k] = 1'b1;
					default: e.dense_fuse[k] = 1'b1;
				endcase
				partner.fire(e);
				rd_chk(aux_area_pkg::W_SLAVE_DENSE, 16'h0020 << k);
				clr;
			end
		end
		e = '0;
		e.dense_num9_64pt = 1'b1;
		partner.fire(e);
		rd_chk(aux_area_pkg::W_SLAVE_DENSE, 16'h4000);
		clr;
		e = '0;
		e.dense_unknown = 1'b1;
		partner.fire(e);
		rd_chk(aux_area_pkg::W_SLAVE_DENSE, 16'h8000);
		clr;
		$display("test dense flags done");
	endtask

	task automatic t_optical;
		aux_area_pkg::err_evt_t e;
		int u;
		logic [4:0] idx;
		logic [15:0] x;
		for (int n = 0; n < 64; n++) begin
			e = '0;
			e.optical_dup[n] = 1'b1;
			partner.fire(e);
			u = n / 2;
			x = 16'h0001 << (2 * (u % 8) + n % 2);
			idx = aux_area_pkg::W_OPTICAL0 + 5'(u / 8);
			rd_chk(idx, x);
			clr;
		end
		$display("test optical flags done");
	endtask

	task automatic t_link;
		wr(aux_area_pkg::W_LINK_HIST, 16'hffff);
		rd_chk(aux_area_pkg::W_LINK_HIST, 16'he1ff);
		check({ctrl.hist_enable, ctrl.hist_reset, ctrl.hist_overwrite,
			ctrl.key_cancel}, 32'hf);
		wr(aux_area_pkg::W_LINK_HIST, 16'h00a5);
		rd_chk(aux_area_pkg::W_LINK_HIST, 16'h00a5);
		check(ctrl.link_set_l0, 32'h5);
		check(ctrl.link_set_l1, 32'ha);
		check(ctrl.key_cancel, 32'h0);
		$display("test link word done");
	endtask

	task automatic t_sys;
		aux_area_pkg::sys_state_t s;
		s = '0;
		s.nodes_l0 = 64'h0123456789abcdef;
		s.nodes_l1 = 64'hfedcba9876543210;
		{s.low_batt, s.cycle_flag, s.netp_l1, s.netp_l0, s.link_mnt_l1,
			s.link_mnt_l0, s.pclink_mnt_l1, s.pclink_mnt_l0, s.host_mnt_l1,
			s.host_mnt_l0, s.cpu_dev_mnt} = 11'h7ff;
		partner.refresh(s);
		for (int i = 0; i < 4; i++) begin
			rd_chk(aux_area_pkg::W_NODES_L0 + 5'(i), s.nodes_l0[16*i+:16]);
			rd_chk(aux_area_pkg::W_NODES_L1 + 5'(i), s.nodes_l1[16*i+:16]);
		end
		rd_chk(aux_area_pkg::W_MOUNTED, 16'hfbf0);
		wr(aux_area_pkg::W_MOUNTED, 16'h0000);
		rd_chk(aux_area_pkg::W_MOUNTED, 16'hfbf0);
		s = '0;
		s.cpu_dev_mnt = 1'b1;
		partner.refresh(s);
		rd_chk(aux_area_pkg::W_MOUNTED, 16'h8000);
		$display("test system words done");
	endtask

	task automatic t_irq;
		aux_area_pkg::err_evt_t e;
		wr(aux_area_pkg::W_IRQ_STATUS, 16'h001f);
		rd_chk(aux_area_pkg::W_IRQ_STATUS, 16'h0000);
		wr(aux_area_pkg::W_IRQ_MASK, 16'h0001);
		rd_chk(aux_area_pkg::W_IRQ_MASK, 16'h0001);
		e = '0;
		e.optical_dup[0] = 1'b1;
		partner.fire(e);
		repeat (2) @(posedge pclk);
		#1 check(irq, 32'h0);
		e = '0;
		e.unit_err[3] = 1'b1;
		partner.fire(e);
		repeat (2) @(posedge pclk);
		#1 check(irq, 32'h1);
		rd_chk(aux_area_pkg::W_IRQ_STATUS, 16'h0009);
		wr(aux_area_pkg::W_IRQ_STATUS, 16'h0001);
		rd_chk(aux_area_pkg::W_IRQ_STATUS, 16'h0008);
		check(irq, 32'h0);
		wr(aux_area_pkg::W_IRQ_MASK, 16'h0008);
		check(irq, 32'h1);
		wr(aux_area_pkg::W_IRQ_STATUS, 16'h0008);
		check(irq, 32'h0);
		clr;
		$display("test interrupt done");
	endtask

	task automatic t_retain;
		wr(aux_area_pkg::W_CONSOLE_KEYS, 16'h1234);
		wr(aux_area_pkg::W_CALENDAR, 16'h5678);
		repeat (100) @(posedge pclk);
		rd_chk(aux_area_pkg::W_CONSOLE_KEYS, 16'h1234);
		rd_chk(aux_area_pkg::W_CALENDAR, 16'h5678);
		check(ctrl.console_keys, 32'h1234);
		check(ctrl.calendar[15:0], 32'h5678);
		$display("test retention done");
	endtask

	// counts and verdict, then stop
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// watchdog well beyond the expected run
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		print_verdict;
	end

	// reset, then the scenarios in turn
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_unit;
		t_restart;
		t_slave;
		t_dense;
		t_optical;
		t_link;
		t_sys;
		t_irq;
		t_retain;
		print_verdict;
	end
endmodule // test_aux_flag_area_bank
